// *** core/dbcr_pkg.sv ***
package dbcr_pkg;
  localparam int unsigned DW = 8;
  localparam int unsigned AW = 8;
  // register offsets
  localparam logic [7:0] ADDR_PART_IDENTITY = 8'h00;
  localparam logic [7:0] ADDR_GENERAL_CONFIGURATION = 8'h01;
  localparam logic [7:0] ADDR_REGULATOR_ENABLES = 8'h02;
  localparam logic [7:0] ADDR_REGULATOR_POWER_STATE = 8'h03;
  localparam logic [7:0] ADDR_SEQUENCE_SLOTS_A = 8'h04;
  localparam logic [7:0] ADDR_SEQUENCE_SLOTS_B = 8'h05;
  localparam logic [7:0] ADDR_COMMON_VOLTAGE_CODE = 8'h06;
  localparam logic [7:0] ADDR_RESERVED_SLOT = 8'h07;
  localparam logic [7:0] ADDR_FAULT_SUPPRESS_A = 8'h08;
  localparam logic [7:0] ADDR_FAULT_SUPPRESS_B = 8'h09;
  localparam logic [7:0] ADDR_FAULT_FLAGS_A = 8'h0A;
  localparam logic [7:0] ADDR_FAULT_FLAGS_B = 8'h0B;
  // configuration fields
  localparam int unsigned CFG_LIVE_FLAGS_BIT = 7;
  localparam int unsigned CFG_AUTOSEQ_BIT = 6;
  localparam int unsigned CFG_RETRY_LSB = 4;
  localparam int unsigned CFG_DEGLITCH_LSB = 2;
  localparam int unsigned CFG_SPREAD_OFF_BIT = 1;
  localparam int unsigned CFG_LOW_FREQ_BIT = 0;
  // regulator enable fields
  localparam int unsigned REG_SEQ_RUN_BIT = 6;
  localparam int unsigned REG_BOOST_BIT = 0;
  localparam logic [7:0] REG_DOWNSTREAM_BITS = 8'h0E;
  localparam int unsigned PART_CODE_LSB = 0;
  localparam int unsigned REVISION_LSB = 4;
  // implemented bits
  localparam logic [7:0] IMPL_CONFIG = 8'hFF;
  localparam logic [7:0] IMPL_ENABLES = 8'h7F;
  localparam logic [7:0] IMPL_POWER_STATE = 8'h3F;
  localparam logic [7:0] IMPL_SLOTS_A = 8'h3F;
  localparam logic [7:0] IMPL_SLOTS_B = 8'h7F;
  localparam logic [7:0] IMPL_SUPPRESS_A = 8'h7F;
  localparam logic [7:0] IMPL_SUPPRESS_B = 8'h18;
  localparam logic [7:0] IMPL_FLAGS_A = 8'h7F;
  localparam logic [7:0] IMPL_FLAGS_B = 8'h1B;
  // reset values
  localparam logic [7:0] RST_CONFIG = 8'h24;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_FLAGS_B = 8'h01;
  // timing
  localparam int unsigned CLK_KHZ = 25000;
  localparam int unsigned RETRY1_MS = 950;
  localparam int unsigned RETRY2_MS = 1900;
  localparam int unsigned RETRY3_MS = 3800;
  localparam int unsigned DEGL0_MS = 30;
  localparam int unsigned DEGL1_MS = 60;
  localparam int unsigned DEGL2_MS = 120;
  localparam int unsigned DEGL3_MS = 250;
  localparam int unsigned RETRY1_CYC = RETRY1_MS * CLK_KHZ;
  localparam int unsigned RETRY2_CYC = RETRY2_MS * CLK_KHZ;
  localparam int unsigned RETRY3_CYC = RETRY3_MS * CLK_KHZ;
  localparam int unsigned DEGL0_CYC = DEGL0_MS * CLK_KHZ;
  localparam int unsigned DEGL1_CYC = DEGL1_MS * CLK_KHZ;
  localparam int unsigned DEGL2_CYC = DEGL2_MS * CLK_KHZ;
  localparam int unsigned DEGL3_CYC = DEGL3_MS * CLK_KHZ;
  localparam int unsigned CYC_W = 32;
endpackage

// *** core/dbcr_flag_if.sv ***
`timescale 1ns/1ps
interface dbcr_flag_if;
  logic [7:0] live;
  logic wr;
  logic [7:0] wdata;
  logic [7:0] flags;
  modport bank (input live, input wr, input wdata, output flags);
  modport owner (output live, output wr, output wdata, input flags);
endinterface

// *** core/dbcr_flag_reg.sv ***
`timescale 1ns/1ps
module dbcr_flag_reg #(
  parameter logic [7:0] IMPL = 8'hFF,
  parameter logic [7:0] RSTV = 8'h00
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // mode
  input wire logic mirror,
  // flag port
  dbcr_flag_if.bank f
);
  logic [7:0] flags_r;
  logic [7:0] keep;

  // a write of 0 clears, a 1 keeps; a live fault in the same cycle still sets
  always_comb begin
    keep = f.wr ? f.wdata : 8'hFF;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      flags_r <= RSTV;
    end else if (mirror) begin
      flags_r <= f.live & IMPL;
    end else begin
      flags_r <= ((flags_r & keep) | f.live) & IMPL;
    end
  end

  assign f.flags = flags_r;
endmodule

// *** core/dbcr_regs.sv ***
`timescale 1ns/1ps
module dbcr_regs
#(
  parameter logic [3:0] SILICON_REVISION = 4'h0,
  parameter logic [3:0] PART_CODE = 4'h5, // arbitrary value
  parameter int unsigned RETRY1_CYCLES = dbcr_pkg::RETRY1_CYC,
  parameter int unsigned RETRY2_CYCLES = dbcr_pkg::RETRY2_CYC,
  parameter int unsigned RETRY3_CYCLES = dbcr_pkg::RETRY3_CYC,
  parameter int unsigned DEGL0_CYCLES = dbcr_pkg::DEGL0_CYC,
  parameter int unsigned DEGL1_CYCLES = dbcr_pkg::DEGL1_CYC,
  parameter int unsigned DEGL2_CYCLES = dbcr_pkg::DEGL2_CYC,
  parameter int unsigned DEGL3_CYCLES = dbcr_pkg::DEGL3_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // register port from the serial engine
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [dbcr_pkg::AW-1:0] reg_addr,
  input wire logic [dbcr_pkg::DW-1:0] reg_wdata,
  output logic [dbcr_pkg::DW-1:0] reg_rdata,
  // analog status and faults (asynchronous)
  input wire logic [7:0] power_state_in,
  input wire logic [7:0] fault_live_a,
  input wire logic [7:0] fault_live_b,
  // sequencer handshake
  input wire logic seq_busy,
  output logic seq_run,
  output logic autoseq_en,
  output logic [5:0] seq_slots_a,
  output logic [6:0] seq_slots_b,
  // regulator controls
  output logic [5:0] manual_en,
  output logic [7:0] vcom_code,
  // timer and converter setup
  output logic live_flags,
  output logic retry_en,
  output logic [dbcr_pkg::CYC_W-1:0] retry_cycles,
  output logic [dbcr_pkg::CYC_W-1:0] deglitch_cycles,
  output logic spread_off,
  output logic low_freq,
  // open-drain fault pin
  output logic fault_pin_n_out,
  output logic fault_pin_n_oe
);
  import dbcr_pkg::*;

  logic [7:0] cfg_r;
  logic [7:0] ena_r;
  logic [7:0] slots_a_r;
  logic [7:0] slots_b_r;
  logic [7:0] vcom_r;
  logic [7:0] supp_a_r;
  logic [7:0] supp_b_r;
  logic [7:0] rdata_r;
  logic [CYC_W-1:0] retry_r;
  logic [CYC_W-1:0] degl_r;
  logic [7:0] pwr_s1_r;
  logic [7:0] pwr_s2_r;
  logic [7:0] fa_s1_r;
  logic [7:0] fa_s2_r;
  logic [7:0] fb_s1_r;
  logic [7:0] fb_s2_r;
  logic [7:0] ena_nxt;
  logic [7:0] rd_nxt;
  logic boost_ready;

  dbcr_flag_if flags_a_if ();
  dbcr_flag_if flags_b_if ();

  // analog levels cross into the clock domain before anything reads them
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pwr_s1_r <= RST_ZERO;
      pwr_s2_r <= RST_ZERO;
      fa_s1_r <= RST_ZERO;
      fa_s2_r <= RST_ZERO;
      fb_s1_r <= RST_ZERO;
      fb_s2_r <= RST_ZERO;
    end else begin
      pwr_s1_r <= power_state_in;
      pwr_s2_r <= pwr_s1_r;
      fa_s1_r <= fault_live_a;
      fa_s2_r <= fa_s1_r;
      fb_s1_r <= fault_live_b;
      fb_s2_r <= fb_s1_r;
    end
  end

  assign boost_ready = pwr_s2_r[REG_BOOST_BIT];

  // downstream enables only stick while the boost is on and ready
  always_comb begin
    ena_nxt = reg_wdata & IMPL_ENABLES;
    if (!(ena_r[REG_BOOST_BIT] && ena_nxt[REG_BOOST_BIT] && boost_ready)) begin
      ena_nxt = ena_nxt & ~REG_DOWNSTREAM_BITS;
    end
  end

  // configuration and control writes; 0x07 decodes to nothing
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cfg_r <= RST_CONFIG;
      ena_r <= RST_ZERO;
      vcom_r <= RST_ZERO;
      supp_a_r <= RST_ZERO;
      supp_b_r <= RST_ZERO;
    end else if (reg_wr) begin
      unique case (reg_addr)
        ADDR_GENERAL_CONFIGURATION: cfg_r <= reg_wdata & IMPL_CONFIG;
        ADDR_REGULATOR_ENABLES: ena_r <= ena_nxt;
        ADDR_COMMON_VOLTAGE_CODE: vcom_r <= reg_wdata;
        ADDR_FAULT_SUPPRESS_A: supp_a_r <= reg_wdata & IMPL_SUPPRESS_A;
        ADDR_FAULT_SUPPRESS_B: supp_b_r <= reg_wdata & IMPL_SUPPRESS_B;
        default: ;
      endcase
    end
  end

  // slot programming frozen while the sequencer runs
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      slots_a_r <= RST_ZERO;
      slots_b_r <= RST_ZERO;
    end else if (reg_wr && !seq_busy) begin
      if (reg_addr == ADDR_SEQUENCE_SLOTS_A) begin
        slots_a_r <= reg_wdata & IMPL_SLOTS_A;
      end
      if (reg_addr == ADDR_SEQUENCE_SLOTS_B) begin
        slots_b_r <= reg_wdata & IMPL_SLOTS_B;
      end
    end
  end

  // fault flag registers
  assign flags_a_if.live = fa_s2_r;
  assign flags_a_if.wr = reg_wr && (reg_addr == ADDR_FAULT_FLAGS_A);
  assign flags_a_if.wdata = reg_wdata;
  assign flags_b_if.live = fb_s2_r;
  assign flags_b_if.wr = reg_wr && (reg_addr == ADDR_FAULT_FLAGS_B);
  assign flags_b_if.wdata = reg_wdata;

  dbcr_flag_reg #(
    .IMPL(IMPL_FLAGS_A),
    .RSTV(RST_ZERO)
  ) u_flags_a (
    .clk(clk),
    .resetn(resetn),
    .mirror(cfg_r[CFG_LIVE_FLAGS_BIT]),
    .f(flags_a_if.bank)
  );

  // hardware reset flag reads set after power-up until cleared
  dbcr_flag_reg #(
    .IMPL(IMPL_FLAGS_B),
    .RSTV(RST_FLAGS_B)
  ) u_flags_b (
    .clk(clk),
    .resetn(resetn),
    .mirror(cfg_r[CFG_LIVE_FLAGS_BIT]),
    .f(flags_b_if.bank)
  );

  // read mux
  always_comb begin
    unique case (reg_addr)
      ADDR_PART_IDENTITY: rd_nxt = {SILICON_REVISION, PART_CODE};
      ADDR_GENERAL_CONFIGURATION: rd_nxt = cfg_r;
      ADDR_REGULATOR_ENABLES: rd_nxt = ena_r;
      ADDR_REGULATOR_POWER_STATE: rd_nxt = pwr_s2_r & IMPL_POWER_STATE;
      ADDR_SEQUENCE_SLOTS_A: rd_nxt = slots_a_r;
      ADDR_SEQUENCE_SLOTS_B: rd_nxt = slots_b_r;
      ADDR_COMMON_VOLTAGE_CODE: rd_nxt = vcom_r;
      ADDR_FAULT_SUPPRESS_A: rd_nxt = supp_a_r;
      ADDR_FAULT_SUPPRESS_B: rd_nxt = supp_b_r;
      ADDR_FAULT_FLAGS_A: rd_nxt = flags_a_if.flags;
      ADDR_FAULT_FLAGS_B: rd_nxt = flags_b_if.flags;
      default: rd_nxt = RST_ZERO;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_r <= RST_ZERO;
    end else if (reg_rd) begin
      rdata_r <= rd_nxt;
    end
  end

  // timer lengths registered so downstream timers see stable counts
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      retry_r <= '0;
      degl_r <= '0;
    end else begin
      unique case (cfg_r[CFG_RETRY_LSB +: 2])
        2'h0: retry_r <= '0;
        2'h1: retry_r <= CYC_W'(RETRY1_CYCLES);
        2'h2: retry_r <= CYC_W'(RETRY2_CYCLES);
        2'h3: retry_r <= CYC_W'(RETRY3_CYCLES);
      endcase
      unique case (cfg_r[CFG_DEGLITCH_LSB +: 2])
        2'h0: degl_r <= CYC_W'(DEGL0_CYCLES);
        2'h1: degl_r <= CYC_W'(DEGL1_CYCLES);
        2'h2: degl_r <= CYC_W'(DEGL2_CYCLES);
        2'h3: degl_r <= CYC_W'(DEGL3_CYCLES);
      endcase
    end
  end

  assign reg_rdata = rdata_r;
  assign retry_cycles = retry_r;
  assign deglitch_cycles = degl_r;
  // manual mode never retries
  assign retry_en = (cfg_r[CFG_RETRY_LSB +: 2] != 2'h0) && cfg_r[CFG_AUTOSEQ_BIT];
  assign live_flags = cfg_r[CFG_LIVE_FLAGS_BIT];
  assign autoseq_en = cfg_r[CFG_AUTOSEQ_BIT];
  assign seq_run = cfg_r[CFG_AUTOSEQ_BIT] & ena_r[REG_SEQ_RUN_BIT];
  assign manual_en = cfg_r[CFG_AUTOSEQ_BIT] ? 6'h00 : ena_r[5:0];
  assign seq_slots_a = slots_a_r[5:0];
  assign seq_slots_b = slots_b_r[6:0];
  assign vcom_code = vcom_r;
  assign spread_off = cfg_r[CFG_SPREAD_OFF_BIT];
  assign low_freq = cfg_r[CFG_LOW_FREQ_BIT];
  // pin only ever pulls low; the pull-up makes the high level
  assign fault_pin_n_out = 1'b0;
  // thermal and reset flags have no mask bit, so they always reach the pin
  assign fault_pin_n_oe = |((flags_a_if.flags & ~supp_a_r) |
                            (flags_b_if.flags & ~supp_b_r));
endmodule

// *** testbench/dbcr_regs_sva.sv ***
`timescale 1ns/1ps
module dbcr_regs_sva (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // host strobes
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic seq_busy,
  // bank outputs
  input wire logic seq_run,
  input wire logic autoseq_en,
  input wire logic [5:0] seq_slots_a,
  input wire logic [5:0] manual_en,
  input wire logic [7:0] vcom_code,
  input wire logic live_flags,
  input wire logic [31:0] retry_cycles,
  input wire logic spread_off,
  input wire logic low_freq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  wire cfg_wr = reg_wr && reg_addr == 8'h01;
  a_flag_mode: assert property (cfg_wr |=> live_flags == $past(reg_wdata[7]))
    else $error("flag mode wrong");
  a_autoseq_bit: assert property (cfg_wr |=> autoseq_en == $past(reg_wdata[6]))
    else $error("autoseq bit wrong");
  a_retry_off: assert property (cfg_wr && reg_wdata[5:4] == 2'h0 |-> ##2 retry_cycles == 0)
    else $error("retry not off");
  a_boost_setup: assert property (cfg_wr |=> {spread_off, low_freq} == $past(reg_wdata[1:0]))
    else $error("boost setup wrong");
  a_manual_off: assert property (autoseq_en |-> manual_en == 6'h00)
    else $error("manual enable under autoseq");
  a_run_gated: assert property (seq_run |-> autoseq_en)
    else $error("run without autoseq");
  a_slot_lock: assert property (seq_busy && reg_wr && reg_addr == 8'h04 |=> $stable(seq_slots_a))
    else $error("slots changed while busy");
  a_boost_first: assert property (|manual_en[3:1] |-> manual_en[0])
    else $error("rail on without boost");
  a_vcom_store: assert property (reg_wr && reg_addr == 8'h06 |=> vcom_code == $past(reg_wdata))
    else $error("vcom not stored");
  cover property (cfg_wr && reg_wdata[6]);
  cover property (seq_busy && reg_wr);
  cover property (manual_en[1]);
endmodule

// *** testbench/dbcr_host.sv ***
`timescale 1ns/1ps
module dbcr_host (
  // clock
  input wire logic clk,
  // register strobes
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // one byte a transfer; data inverted once released so stale values never match
  task automatic put(input logic [7:0] a, input logic [7:0] d, input logic rd);
    @(negedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= !rd && a != 8'h07;
    reg_rd <= rd;
    @(negedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    reg_wdata <= ~d;
  endtask
endmodule

// *** testbench/dbcr_regs_test.sv ***
`timescale 1ns/1ps
module dbcr_regs_test;
  logic clk, resetn, reg_wr, reg_rd, seq_busy, seq_run, autoseq_en, live_flags;
  logic retry_en, spread_off, low_freq, fault_pin_n_out, fault_pin_n_oe;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, power_state_in, fault_live_a, fault_live_b;
  logic [7:0] vcom_code, v;
  logic [5:0] seq_slots_a, manual_en;
  logic [6:0] seq_slots_b;
  logic [31:0] retry_cycles, deglitch_cycles;
  logic [31:0] rtab[4] = '{32'h0, dbcr_pkg::RETRY1_CYC, dbcr_pkg::RETRY2_CYC,
    dbcr_pkg::RETRY3_CYC};
  logic [31:0] dtab[4] = '{dbcr_pkg::DEGL0_CYC, dbcr_pkg::DEGL1_CYC, dbcr_pkg::DEGL2_CYC,
    dbcr_pkg::DEGL3_CYC};
  logic [7:0] expq[$];
  string nameq[$];
  int mismatches = 0;
  int tests_run = 0;
  dbcr_host host (.clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);
  dbcr_regs DUT (
    .clk, .resetn, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .power_state_in,
    .fault_live_a, .fault_live_b, .seq_busy, .seq_run, .autoseq_en, .seq_slots_a,
    .seq_slots_b, .manual_en, .vcom_code, .live_flags, .retry_en, .retry_cycles,
    .deglitch_cycles, .spread_off, .low_freq, .fault_pin_n_out, .fault_pin_n_oe);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
    expq.push_back(e);
    nameq.push_back(n);
    host.put(a, 8'h00, 1'b1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.put(a, d, 1'b0);
  endtask
  task automatic settle(input logic [7:0] a, input logic [7:0] b);
    fault_live_a = a;
    fault_live_b = b;
    repeat (4) @(negedge clk);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // read data is registered, so it is judged one edge after the strobe
  always @(posedge clk) begin
    if (reg_rd === 1'b1) begin
      @(negedge clk);
      chk(nameq.pop_front(), {24'h0, expq.pop_front()}, {24'h0, reg_rdata});
    end
  end
  initial begin
    #400000;
    mismatches++;
    report_and_stop;
  end
  initial begin
    void'($urandom(19));
    resetn = 1'b0;
    seq_busy = 1'b0;
    power_state_in = 8'h00;
    settle(8'h00, 8'h00);
    repeat (8) @(negedge clk);
    resetn = 1'b1;
    wr(8'h00, 8'hFF);
    rd(8'h00, 8'h05, "identity");
    rd(8'h01, 8'h24, "config_reset");
    rd(8'h0B, 8'h01, "flags_b_reset");
    rd(8'h0C, 8'h00, "unmapped");
    for (int c = 0; c < 4; c++) begin
      v = {2'h0, c[1:0], 2'(3 - c), 2'($urandom)};
      wr(8'h01, v);
      rd(8'h01, v, "config");
      chk("retry", rtab[c], retry_cycles);
      chk("deglitch", dtab[3 - c], deglitch_cycles);
      chk("boost_setup", {30'h0, v[1:0]}, {30'h0, spread_off, low_freq});
    end
    wr(8'h01, 8'h10);
    chk("retry_manual", 1'b0, retry_en);
    chk("pin_reset", 1'b1, fault_pin_n_oe);
    chk("pin_out", 1'b0, fault_pin_n_out);
    wr(8'h0B, 8'hFE);
    chk("pin_idle", 1'b0, fault_pin_n_oe);
    settle(8'h08, 8'h00);
    settle(8'h00, 8'h00);
    chk("pin_low", 1'b1, fault_pin_n_oe);
    rd(8'h0A, 8'h08, "latched");
    wr(8'h0A, 8'hFF);
    rd(8'h0A, 8'h08, "kept");
    wr(8'h08, 8'h08);
    chk("pin_masked", 1'b0, fault_pin_n_oe);
    wr(8'h0A, 8'h77);
    rd(8'h0A, 8'h00, "cleared");
    wr(8'h01, 8'h80);
    settle(8'h05, 8'h18);
    rd(8'h0A, 8'h05, "mirror_a");
    rd(8'h0B, 8'h18, "mirror_b");
    settle(8'h00, 8'h00);
    rd(8'h0A, 8'h00, "mirror_off");
    wr(8'h01, 8'h00);
    wr(8'h02, 8'h0F);
    rd(8'h02, 8'h01, "boost_first");
    wr(8'h02, 8'h0F);
    rd(8'h02, 8'h01, "boost_not_ready");
    power_state_in = 8'h01;
    repeat (3) @(negedge clk);
    rd(8'h03, 8'h01, "power_state");
    wr(8'h02, 8'h0F);
    rd(8'h02, 8'h0F, "boost_ready");
    chk("manual_en", 32'h0F, {26'h0, manual_en});
    wr(8'h04, 8'h12);
    wr(8'h01, 8'h50);
    chk("manual_off", 32'h0, {26'h0, manual_en});
    chk("retry_auto", 1'b1, retry_en);
    wr(8'h02, 8'h40);
    chk("run", 1'b1, seq_run);
    seq_busy = 1'b1;
    wr(8'h04, 8'h2D);
    wr(8'h05, 8'h7F);
    rd(8'h04, 8'h12, "slots_locked");
    rd(8'h05, 8'h00, "slots_b_locked");
    seq_busy = 1'b0;
    wr(8'h04, 8'h2D);
    v = 8'($urandom);
    wr(8'h05, v);
    rd(8'h04, 8'h2D, "slots");
    rd(8'h05, v & 8'h7F, "slots_b");
    chk("slots_b_out", {24'h0, v & 8'h7F}, {25'h0, seq_slots_b});
    wr(8'h09, 8'hFF);
    rd(8'h09, 8'h18, "mask_b_bits");
    v = 8'($urandom);
    wr(8'h06, v);
    rd(8'h06, v, "vcom");
    repeat (2) @(negedge clk);
    report_and_stop;
  end
endmodule
bind dbcr_regs dbcr_regs_sva chk (.clk, .resetn, .reg_wr, .reg_addr, .reg_wdata, .seq_busy,
  .seq_run, .autoseq_en, .seq_slots_a, .manual_en, .vcom_code, .live_flags, .retry_cycles,
  .spread_off, .low_freq);
